/* logic/mlt_consts.vh */
`ifndef MLT_CONSTS_VH
`define MLT_CONSTS_VH

`define MLT_STAT_N 64
`define MLT_STAT_LAST 6'h3f
`define MLT_KEY_W 60
`define MLT_AGE_W 24
`define MLT_AGE_RST 24'h00012c
`define MLT_AGE_MIN 24'h00000a
`define MLT_AGE_MAX 24'h989680
`define MLT_CLK_HZ 200000000
`define MLT_TICK_S 1

`define MLT_MODE_AUTO 2'h0
`define MLT_MODE_DIS 2'h1
`define MLT_MODE_SEC 2'h2

`define MLT_REG_CTRL 8'h00
`define MLT_REG_AGE 8'h04
`define MLT_REG_MODE 8'h08
`define MLT_REG_SEL 8'h0c
`define MLT_REG_KEY_LO 8'h10
`define MLT_REG_KEY_HI 8'h14
`define MLT_REG_PORTS 8'h18
`define MLT_REG_STATUS 8'h1c
`define MLT_REG_RES_LO 8'h20
`define MLT_REG_RES_HI 8'h24
`define MLT_REG_RES_PORTS 8'h28

`define MLT_CTRL_AGE_DIS 0
`define MLT_CTRL_FLUSH 1
`define MLT_CTRL_FIND 2
`define MLT_CTRL_ST_WR 3
`define MLT_CTRL_ST_DEL 4

`define MLT_ST_BUSY 0
`define MLT_ST_FOUND 1
`define MLT_ST_STATIC 2

`endif

/* logic/mlt_table.v */
`timescale 1ns/100ps
`default_nettype none
`include "mlt_consts.vh"

module mlt_table #(
  parameter PORTS = 8,
  parameter PW = 3,
  parameter DYN_N = 64,
  parameter TICK_CYC = `MLT_CLK_HZ * `MLT_TICK_S
) (
  // Clock and reset
  input wire i_sys_clk,
  input wire i_srst,
  // Wishbone slave
  input wire i_wb_cyc,
  input wire i_wb_stb,
  input wire i_wb_we,
  input wire [7:0] i_wb_adr,
  input wire [3:0] i_wb_sel,
  input wire [31:0] i_wb_dat,
  output reg o_wb_ack,
  output reg [31:0] o_wb_dat,
  // Frame lookup request
  input wire i_frm_valid,
  input wire [PW-1:0] i_frm_port,
  input wire [11:0] i_frm_vlan,
  input wire [47:0] i_frm_dest_station_addr,
  input wire [47:0] i_frm_src_station_addr,
  input wire [PORTS-1:0] i_frm_vlan_ports,
  output reg o_frm_ready,
  // Forwarding answer
  output reg o_fwd_valid,
  output reg [PORTS-1:0] o_fwd_ports,
  output reg o_fwd_drop,
  // Mode override from another function
  input wire [PORTS-1:0] i_mode_lock,
  input wire [2*PORTS-1:0] i_lock_mode
);

  localparam S_IDLE = 2'h0;
  localparam S_SCAN = 2'h1;
  localparam S_DONE = 2'h2;
  localparam [31:0] TICK_LAST = TICK_CYC - 1;

  // Tables
  reg [`MLT_STAT_N-1:0] st_v_q;
  reg [`MLT_KEY_W-1:0] st_key_q [0:`MLT_STAT_N-1];
  reg [PORTS-1:0] st_ports_q [0:`MLT_STAT_N-1];
  reg [DYN_N-1:0] dyn_v_q;
  reg [`MLT_KEY_W-1:0] dyn_key_q [0:DYN_N-1];
  reg [PW-1:0] dyn_port_q [0:DYN_N-1];
  reg [`MLT_AGE_W-1:0] dyn_age_q [0:DYN_N-1];

  // Software registers
  reg age_dis_q;
  reg [`MLT_AGE_W-1:0] age_time_q;
  reg [2*PORTS-1:0] mode_q;
  reg [5:0] sel_q;
  reg [`MLT_KEY_W-1:0] key_q;
  reg [PORTS-1:0] ports_q;
  reg find_q;
  reg found_q;
  reg [`MLT_KEY_W-1:0] res_key_q;
  reg res_st_q;
  reg [PORTS-1:0] res_ports_q;

  // Scan engine
  reg [1:0] state_q;
  reg [5:0] idx_q;
  reg is_find_q;
  reg [PW-1:0] rx_port_q;
  reg [11:0] vlan_q;
  reg [47:0] dst_q;
  reg [47:0] src_q;
  reg [PORTS-1:0] vports_q;
  reg dhit_s_q, dhit_d_q, shit_s_q, shit_d_q, free_v_q;
  reg [PORTS-1:0] dmask_q;
  reg [PW-1:0] dport_q;
  reg [5:0] sidx_q, free_idx_q;
  reg [31:0] tick_cnt_q;
  reg tick_q;

  integer i;

  wire [`MLT_KEY_W-1:0] sk = st_key_q[idx_q];
  wire [`MLT_KEY_W-1:0] dk = dyn_key_q[idx_q];
  wire s_live = st_v_q[idx_q];
  wire d_in = ({26'h0, idx_q} < DYN_N);
  wire d_live = d_in && dyn_v_q[idx_q];
  wire [`MLT_KEY_W-1:0] dst_key = {vlan_q, dst_q};
  wire [`MLT_KEY_W-1:0] src_key = {vlan_q, src_q};
  wire s_ok = s_live && (sk >= key_q) && (!found_q || sk < res_key_q);
  wire d_ok = d_live && (dk >= key_q) && (!found_q || dk < res_key_q);
  wire [PORTS-1:0] one = {{(PORTS-1){1'b0}}, 1'b1};
  wire [PORTS-1:0] rx_bit = one << rx_port_q;
  wire [PORTS-1:0] dport_bit = one << dport_q;
  wire [PORTS-1:0] dyn_bit = one << dyn_port_q[idx_q];
  wire [1:0] rx_mode = i_mode_lock[rx_port_q] ? i_lock_mode[2*rx_port_q +: 2]
                                             : mode_q[2*rx_port_q +: 2];

  // Bus decode; the request is served at the edge that raises ack
  wire wb_go = i_wb_cyc && i_wb_stb && !o_wb_ack;
  wire wb_wr = wb_go && i_wb_we;
  wire [31:0] wmask = {{8{i_wb_sel[3]}}, {8{i_wb_sel[2]}},
                       {8{i_wb_sel[1]}}, {8{i_wb_sel[0]}}};
  wire cmd_wr = wb_wr && (i_wb_adr == `MLT_REG_CTRL) && i_wb_sel[0];
  wire idle = (state_q == S_IDLE);

  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [31:0] m;
    begin
      merge = (old & ~m) | (nw & m);
    end
  endfunction

  reg [2*PORTS-1:0] lock2;
  reg [31:0] mode_new;
  reg [31:0] age_new;
  reg [31:0] sel_new, khi_new, ports_new;
  always @* begin
    for (i = 0; i < PORTS; i = i + 1) begin
      lock2[2*i +: 2] = {2{i_mode_lock[i]}};
    end
    mode_new = merge({{(32-2*PORTS){1'b0}}, mode_q}, i_wb_dat, wmask);
    age_new = merge({8'h0, age_time_q}, i_wb_dat, wmask);
    sel_new = merge({26'h0, sel_q}, i_wb_dat, wmask);
    khi_new = merge({4'h0, key_q[`MLT_KEY_W-1:32]}, i_wb_dat, wmask);
    ports_new = merge({{(32-PORTS){1'b0}}, ports_q}, i_wb_dat, wmask);
  end

  // One-second tick for aging
  always @(posedge i_sys_clk) begin
    if (i_srst) begin
      tick_cnt_q <= 32'h0;
      tick_q <= 1'b0;
    end else begin
      tick_q <= (tick_cnt_q == TICK_LAST);
      tick_cnt_q <= (tick_cnt_q == TICK_LAST) ? 32'h0 : tick_cnt_q + 32'h1;
    end
  end

  // Register file and bus answer
  always @(posedge i_sys_clk) begin
    if (i_srst) begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= 32'h0;
      age_dis_q <= 1'b0;
      age_time_q <= `MLT_AGE_RST;
      mode_q <= {(2*PORTS){1'b0}};
      sel_q <= 6'h0;
      key_q <= {`MLT_KEY_W{1'b0}};
      ports_q <= {PORTS{1'b0}};
    end else begin
      o_wb_ack <= wb_go;
      if (wb_wr) begin
        case (i_wb_adr)
          `MLT_REG_CTRL: if (i_wb_sel[0]) age_dis_q <= i_wb_dat[`MLT_CTRL_AGE_DIS];
          `MLT_REG_AGE:
            if (age_new[`MLT_AGE_W-1:0] >= `MLT_AGE_MIN && age_new[31:`MLT_AGE_W] == 8'h0 &&
                age_new[`MLT_AGE_W-1:0] <= `MLT_AGE_MAX) begin
              age_time_q <= age_new[`MLT_AGE_W-1:0];
            end
          `MLT_REG_MODE:
            mode_q <= (mode_q & lock2) | (mode_new[2*PORTS-1:0] & ~lock2);
          `MLT_REG_SEL: sel_q <= sel_new[5:0];
          `MLT_REG_KEY_LO: key_q[31:0] <= merge(key_q[31:0], i_wb_dat, wmask);
          `MLT_REG_KEY_HI: key_q[`MLT_KEY_W-1:32] <= khi_new[`MLT_KEY_W-33:0];
          `MLT_REG_PORTS:
            ports_q <= ports_new[PORTS-1:0];
          default: ;
        endcase
      end
      if (wb_go) begin
        case (i_wb_adr)
          `MLT_REG_CTRL: o_wb_dat <= {31'h0, age_dis_q};
          `MLT_REG_AGE: o_wb_dat <= {8'h0, age_time_q};
          `MLT_REG_MODE: o_wb_dat <= {{(32-2*PORTS){1'b0}}, mode_q};
          `MLT_REG_SEL: o_wb_dat <= {26'h0, sel_q};
          `MLT_REG_KEY_LO: o_wb_dat <= key_q[31:0];
          `MLT_REG_KEY_HI: o_wb_dat <= {4'h0, key_q[59:32]};
          `MLT_REG_PORTS: o_wb_dat <= {{(32-PORTS){1'b0}}, ports_q};
          `MLT_REG_STATUS: o_wb_dat <= {29'h0, res_st_q, found_q, !idle || find_q};
          `MLT_REG_RES_LO: o_wb_dat <= res_key_q[31:0];
          `MLT_REG_RES_HI: o_wb_dat <= {4'h0, res_key_q[59:32]};
          `MLT_REG_RES_PORTS: o_wb_dat <= {{(32-PORTS){1'b0}}, res_ports_q};
          default: o_wb_dat <= 32'h0;
        endcase
      end
    end
  end

  // Tables, aging and the scan engine share one process so that a learn
  // written late in the block always wins over aging or a flush.
  always @(posedge i_sys_clk) begin
    if (i_srst) begin
      st_v_q <= {`MLT_STAT_N{1'b0}};
      dyn_v_q <= {DYN_N{1'b0}};
      state_q <= S_IDLE;
      idx_q <= 6'h0;
      is_find_q <= 1'b0;
      find_q <= 1'b0;
      found_q <= 1'b0;
      res_key_q <= {`MLT_KEY_W{1'b0}};
      res_st_q <= 1'b0;
      res_ports_q <= {PORTS{1'b0}};
      o_frm_ready <= 1'b0;
      o_fwd_valid <= 1'b0;
      o_fwd_ports <= {PORTS{1'b0}};
      o_fwd_drop <= 1'b0;
      rx_port_q <= {PW{1'b0}};
      vlan_q <= 12'h0;
      dst_q <= 48'h0;
      src_q <= 48'h0;
      vports_q <= {PORTS{1'b0}};
      {dhit_s_q, dhit_d_q, shit_s_q, shit_d_q, free_v_q} <= 5'h0;
      dmask_q <= {PORTS{1'b0}};
      dport_q <= {PW{1'b0}};
      sidx_q <= 6'h0;
      free_idx_q <= 6'h0;
    end else begin
      o_fwd_valid <= 1'b0;
      if (tick_q && !age_dis_q) begin
        for (i = 0; i < DYN_N; i = i + 1) begin
          if (dyn_v_q[i]) begin
            if (dyn_age_q[i] >= age_time_q - `MLT_AGE_W'h1) begin
              dyn_v_q[i] <= 1'b0;
            end else begin
              dyn_age_q[i] <= dyn_age_q[i] + `MLT_AGE_W'h1;
            end
          end
        end
      end
      if (cmd_wr && i_wb_dat[`MLT_CTRL_FLUSH]) dyn_v_q <= {DYN_N{1'b0}};
      if (cmd_wr && i_wb_dat[`MLT_CTRL_FIND]) find_q <= 1'b1;
      if (cmd_wr && i_wb_dat[`MLT_CTRL_ST_WR]) begin
        st_v_q[sel_q] <= 1'b1;
        st_key_q[sel_q] <= key_q;
        st_ports_q[sel_q] <= ports_q;
      end
      if (cmd_wr && i_wb_dat[`MLT_CTRL_ST_DEL]) st_v_q[sel_q] <= 1'b0;
      case (state_q)
        S_IDLE: begin
          idx_q <= 6'h0;
          {dhit_s_q, dhit_d_q, shit_s_q, shit_d_q, free_v_q} <= 5'h0;
          if (o_frm_ready && i_frm_valid) begin
            o_frm_ready <= 1'b0;
            is_find_q <= 1'b0;
            rx_port_q <= i_frm_port;
            vlan_q <= i_frm_vlan;
            dst_q <= i_frm_dest_station_addr;
            src_q <= i_frm_src_station_addr;
            vports_q <= i_frm_vlan_ports;
            state_q <= S_SCAN;
          end else if (find_q) begin
            o_frm_ready <= 1'b0;
            // A new find command in this very cycle stays pending
            if (!(cmd_wr && i_wb_dat[`MLT_CTRL_FIND])) find_q <= 1'b0;
            is_find_q <= 1'b1;
            found_q <= 1'b0;
            state_q <= S_SCAN;
          end else begin
            o_frm_ready <= 1'b1;
          end
        end
        S_SCAN: begin
          if (is_find_q) begin
            // Keep the smallest {VLAN, address} at or above the start key
            if (s_ok && (!d_ok || sk <= dk)) begin
              found_q <= 1'b1;
              res_key_q <= sk;
              res_st_q <= 1'b1;
              res_ports_q <= st_ports_q[idx_q];
            end else if (d_ok) begin
              found_q <= 1'b1;
              res_key_q <= dk;
              res_st_q <= 1'b0;
              res_ports_q <= dyn_bit;
            end
          end else begin
            if (s_live && sk == dst_key) begin
              dhit_s_q <= 1'b1;
              dmask_q <= st_ports_q[idx_q];
            end
            if (d_live && dk == dst_key) begin
              dhit_d_q <= 1'b1;
              dport_q <= dyn_port_q[idx_q];
            end
            if (s_live && sk == src_key) shit_s_q <= 1'b1;
            if (d_live && dk == src_key) begin
              shit_d_q <= 1'b1;
              sidx_q <= idx_q;
            end
            if (d_in && !dyn_v_q[idx_q] && !free_v_q) begin
              free_v_q <= 1'b1;
              free_idx_q <= idx_q;
            end
          end
          idx_q <= idx_q + 6'h1;
          if (idx_q == `MLT_STAT_LAST) state_q <= S_DONE;
        end
        S_DONE: begin
          state_q <= S_IDLE;
          if (!is_find_q) begin
            o_fwd_valid <= 1'b1;
            o_fwd_drop <= 1'b0;
            if (rx_mode == `MLT_MODE_SEC && !shit_s_q) begin
              o_fwd_drop <= 1'b1;
              o_fwd_ports <= {PORTS{1'b0}};
            end else if (dhit_s_q) begin
              o_fwd_ports <= dmask_q;
            end else if (dhit_d_q) begin
              o_fwd_ports <= dport_bit & ~rx_bit;
            end else begin
              o_fwd_ports <= vports_q & ~rx_bit;
            end
            // Disabled and secure ports fall through with no learning
            if (rx_mode == `MLT_MODE_AUTO && !shit_s_q) begin
              if (shit_d_q) begin
                dyn_v_q[sidx_q] <= 1'b1;
                dyn_age_q[sidx_q] <= `MLT_AGE_W'h0;
                dyn_port_q[sidx_q] <= rx_port_q;
              end else if (free_v_q) begin
                dyn_v_q[free_idx_q] <= 1'b1;
                dyn_key_q[free_idx_q] <= src_key;
                dyn_age_q[free_idx_q] <= `MLT_AGE_W'h0;
                dyn_port_q[free_idx_q] <= rx_port_q;
              end
            end
          end
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end

endmodule
`default_nettype wire

/* tb/mlt_frm_src.sv */
`timescale 1ns/100ps
`default_nettype none
module mlt_frm_src #(parameter PORTS = 8, parameter PW = 3) (
  // Clock and answers
  input wire logic i_sys_clk,
  input wire logic i_frm_ready,
  input wire logic i_fwd_valid,
  input wire logic [PORTS-1:0] i_fwd_ports,
  input wire logic i_fwd_drop,
  // Frame request
  output logic o_frm_valid,
  output logic [PW-1:0] o_frm_port,
  output logic [11:0] o_frm_vlan,
  output logic [47:0] o_dest,
  output logic [47:0] o_src,
  output logic [PORTS-1:0] o_vlan_ports
);
  initial {o_frm_valid, o_frm_port, o_frm_vlan, o_dest, o_src, o_vlan_ports} = '0;
  task automatic send(input int gap, input logic [PW-1:0] p, input logic [47:0] da,
                      input logic [47:0] sa, output logic [PORTS:0] res);
    int n;
    n = 0;
    repeat (gap + 1) @(posedge i_sys_clk);
    o_frm_valid <= 1'b1;
    o_frm_port <= p;
    o_frm_vlan <= 12'h005;
    o_dest <= da;
    o_src <= sa;
    o_vlan_ports <= '1;
    do @(posedge i_sys_clk); while (!i_frm_ready && ++n < 100);
    // Released address lines flip so a stale address can never look valid
    o_frm_valid <= 1'b0;
    o_dest <= ~da;
    o_src <= ~sa;
    do @(posedge i_sys_clk); while (!i_fwd_valid && ++n < 300);
    res = i_fwd_valid ? {i_fwd_drop, i_fwd_ports} : 'x;
  endtask
endmodule
`default_nettype wire

/* tb/mlt_table_props.sv */
`timescale 1ns/100ps
`default_nettype none
module mlt_table_props #(parameter PORTS = 8) (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_srst,
  // Bus
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic o_wb_ack,
  // Frames
  input wire logic i_frm_valid,
  input wire logic o_frm_ready,
  input wire logic o_fwd_valid,
  input wire logic [PORTS-1:0] o_fwd_ports,
  input wire logic o_fwd_drop
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_srst);
  sequence s_take; i_frm_valid && o_frm_ready; endsequence
  sequence s_req; i_wb_cyc && i_wb_stb && !o_wb_ack; endsequence
  fwd_latency_a: assert property (s_take |-> ##66 o_fwd_valid)
    else $error("answer late or early");
  fwd_busy_a: assert property (s_take |=> (!o_fwd_valid && !o_frm_ready)[*8])
    else $error("engine not busy");
  fwd_pulse_a: assert property (o_fwd_valid |=> !o_fwd_valid)
    else $error("answer longer than a cycle");
  ready_back_a: assert property (o_fwd_valid |-> ##[1:2] o_frm_ready)
    else $error("ready not back");
  ports_hold_a: assert property (!o_fwd_valid |-> $stable({o_fwd_drop, o_fwd_ports}))
    else $error("egress mask moved");
  drop_empty_a: assert property (o_fwd_valid && o_fwd_drop |-> o_fwd_ports == '0)
    else $error("dropped frame has ports");
  ack_once_a: assert property (s_req |=> o_wb_ack ##1 !o_wb_ack)
    else $error("bus ack not one cycle");
  ack_cause_a: assert property (o_wb_ack |-> $past(i_wb_cyc && i_wb_stb))
    else $error("ack without request");
endmodule
bind mlt_table mlt_table_props #(.PORTS(PORTS)) u_props (.i_sys_clk(i_sys_clk),
  .i_srst(i_srst), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .o_wb_ack(o_wb_ack),
  .i_frm_valid(i_frm_valid), .o_frm_ready(o_frm_ready), .o_fwd_valid(o_fwd_valid),
  .o_fwd_ports(o_fwd_ports), .o_fwd_drop(o_fwd_drop));
`default_nettype wire

/* tb/testbench.sv */
`timescale 1ns/100ps
`default_nettype none
`include "mlt_consts.vh"
module testbench;
  logic i_sys_clk, i_srst, cyc, stb, we, ack, fv, fr_rdy, fwd_v, fwd_d;
  logic [7:0] adr, fwd_p, vp, lock;
  logic [31:0] wd, rd_d, q;
  logic [2:0] fport;
  logic [11:0] fvlan;
  logic [47:0] fda, fsa;
  logic [15:0] lmode;
  int fail_count = 0;
  int cmp_count = 0;
  localparam logic [47:0] A = 48'ha1, C = 48'h10, G = 48'hc3, X = 48'h0bad_0000_0001;
  mlt_table #(.TICK_CYC(20)) dut (.i_sys_clk(i_sys_clk), .i_srst(i_srst),
    .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'hf),
    .i_wb_dat(wd), .o_wb_ack(ack), .o_wb_dat(rd_d), .i_frm_valid(fv), .i_frm_port(fport),
    .i_frm_vlan(fvlan), .i_frm_dest_station_addr(fda), .i_frm_src_station_addr(fsa),
    .i_frm_vlan_ports(vp), .o_frm_ready(fr_rdy), .o_fwd_valid(fwd_v), .o_fwd_ports(fwd_p),
    .o_fwd_drop(fwd_d), .i_mode_lock(lock), .i_lock_mode(lmode));
  mlt_frm_src u_src (.i_sys_clk(i_sys_clk), .i_frm_ready(fr_rdy), .i_fwd_valid(fwd_v),
    .i_fwd_ports(fwd_p), .i_fwd_drop(fwd_d), .o_frm_valid(fv), .o_frm_port(fport),
    .o_frm_vlan(fvlan), .o_dest(fda), .o_src(fsa), .o_vlan_ports(vp));
  initial begin
    i_sys_clk = 1'b0;
    forever #2.5 i_sys_clk = ~i_sys_clk;
  end
  task automatic end_sim;
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge i_sys_clk);
    {cyc, stb, we, adr, wd} <= {2'b11, w, a, d};
    do @(posedge i_sys_clk); while (!ack && ++n < 50);
    q = rd_d;
    {cyc, stb} <= 2'b00;
    if (n >= 50) begin
      fail_count++;
      $display("BAD %0t bus answer timed out", $time);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, '0);
    chk(q, e);
  endtask
  task automatic fr(input int g, input logic [2:0] p, input logic [47:0] da,
                    input logic [47:0] sa, input logic [8:0] e);
    logic [8:0] r;
    u_src.send(g, p, da, sa, r);
    chk({23'h0, r}, {23'h0, e});
  endtask
  task automatic t_regs;
    rd(`MLT_REG_AGE, 32'h12c);
    rd(`MLT_REG_CTRL, 32'h0);
    rd(8'h3c, 32'h0);
    // Aging stays off until the aging test so early entries survive
    wb(1'b1, `MLT_REG_CTRL, 32'h1);
    wb(1'b1, `MLT_REG_AGE, 32'h9);
    rd(`MLT_REG_AGE, 32'h12c);
    wb(1'b1, `MLT_REG_AGE, 32'h989681);
    rd(`MLT_REG_AGE, 32'h12c);
    wb(1'b1, `MLT_REG_AGE, 32'h989680);
    rd(`MLT_REG_AGE, 32'h989680);
    wb(1'b1, `MLT_REG_AGE, 32'ha);
    rd(`MLT_REG_AGE, 32'ha);
  endtask
  task automatic t_learn;
    fr(0, 2, X, A, 9'h0fb);
    fr(3, 5, A, G, 9'h004);
    wb(1'b1, `MLT_REG_MODE, 32'h40);
    fr(0, 3, X, 48'hb0, 9'h0f7);
    fr(0, 0, 48'hb0, G, 9'h0fe);
  endtask
  task automatic t_static;
    wb(1'b1, `MLT_REG_KEY_LO, C[31:0]);
    wb(1'b1, `MLT_REG_KEY_HI, 32'h0005_0000);
    wb(1'b1, `MLT_REG_PORTS, 32'h30);
    wb(1'b1, `MLT_REG_SEL, 32'h0);
    wb(1'b1, `MLT_REG_CTRL, 32'h9);
    fr(0, 0, C, G, 9'h030);
    wb(1'b1, `MLT_REG_MODE, 32'h240);
    fr(0, 4, A, 48'hd0, 9'h100);
    fr(2, 4, A, C, 9'h004);
  endtask
  task automatic t_lock;
    @(posedge i_sys_clk);
    lock <= 8'h40;
    lmode <= 16'h1000;
    wb(1'b1, `MLT_REG_MODE, 32'h2240);
    rd(`MLT_REG_MODE, 32'h0240);
    fr(0, 6, X, 48'he0, 9'h0bf);
    fr(0, 0, 48'he0, G, 9'h0fe);
  endtask
  task automatic find(input logic [31:0] k);
    int n;
    n = 0;
    wb(1'b1, `MLT_REG_KEY_LO, k);
    wb(1'b1, `MLT_REG_CTRL, 32'h5);
    do wb(1'b0, `MLT_REG_STATUS, '0); while (q[0] && ++n < 50);
  endtask
  task automatic t_read;
    wb(1'b1, `MLT_REG_KEY_HI, 32'h0);
    find(32'h0);
    chk(q, 32'h6);
    rd(`MLT_REG_RES_LO, 32'h10);
    rd(`MLT_REG_RES_HI, 32'h0005_0000);
    rd(`MLT_REG_RES_PORTS, 32'h30);
    wb(1'b1, `MLT_REG_KEY_HI, 32'h0005_0000);
    find(32'h11);
    chk(q, 32'h2);
    rd(`MLT_REG_RES_LO, 32'ha1);
    rd(`MLT_REG_RES_PORTS, 32'h4);
  endtask
  task automatic t_age;
    repeat (400) @(posedge i_sys_clk);
    fr(0, 5, A, G, 9'h004);
    wb(1'b1, `MLT_REG_CTRL, 32'h0);
    repeat (400) @(posedge i_sys_clk);
    fr(0, 0, A, G, 9'h0fe);
    fr(0, 0, C, G, 9'h030);
    wb(1'b1, `MLT_REG_CTRL, 32'h2);
    fr(0, 1, G, A, 9'h0fd);
    wb(1'b1, `MLT_REG_CTRL, 32'h10);
    fr(0, 1, C, A, 9'h0fd);
  endtask
  initial begin
    #100000;
    fail_count++;
    end_sim();
  end
  initial begin
    {i_srst, cyc, stb, we, adr, wd, lock, lmode} = {1'b1, 67'h0};
    repeat (12) @(posedge i_sys_clk);
    i_srst <= 1'b0;
    t_regs();
    t_learn();
    t_static();
    t_lock();
    t_read();
    t_age();
    end_sim();
  end
endmodule
`default_nettype wire
